// [src/ewio_port.sv]
// Purpose: eight-bit general purpose io port with wake inputs, axi4-lite
// Assumes: pin inputs synchronous to aclk; lcd owns segment data and field
// Notes:   pin outputs lag register writes by one cycle
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
module ewio_port
  import ewio_pkg::*;
(
  input  wire logic        aclk,                 // system clock
  input  wire logic        aresetn,              // sync reset, active low
  input  wire logic [17:0] awaddr,               // write address
  input  wire logic        awvalid,              // write address valid
  output logic             awready,              // write address ready
  input  wire logic [31:0] wdata,                // write data
  input  wire logic [3:0]  wstrb,                // write byte enables
  input  wire logic        wvalid,               // write data valid
  output logic             wready,               // write data ready
  output logic [1:0]       bresp,                // write response
  output logic             bvalid,               // write response valid
  input  wire logic        bready,               // write response ready
  input  wire logic [17:0] araddr,               // read address
  input  wire logic        arvalid,              // read address valid
  output logic             arready,              // read address ready
  output logic [31:0]      rdata,                // read data
  output logic [1:0]       rresp,                // read response
  output logic             rvalid,               // read data valid
  input  wire logic        rready,               // read data ready
  input  wire logic [7:0]  pin_in,               // pin levels
  output logic [7:0]       pin_out,              // pin drive values
  output logic [7:0]       pin_oe,               // pin drive enables
  output logic [7:0]       pullup_on,            // weak pull-up enables
  input  wire logic [3:0]  segment_select_field, // lcd segment select
  input  wire logic [7:0]  lcd_segment_output,   // lcd segment data
  output logic             irq                   // wake interrupt level
);

  typedef struct packed {
    logic [7:0]  pfs;
    logic [7:0]  pdl;
    logic [7:0]  pue;
    logic [7:0]  dir;
    logic [7:0]  ist;
    logic [7:0]  imask;
    logic [7:0]  pin_prev;
    logic [7:0]  pin_out;
    logic [7:0]  pin_oe;
    logic [7:0]  pull;
    logic        irq;
    logic        awready;
    logic        wready;
    logic        aw_got;
    logic        w_got;
    logic [17:0] waddr;
    logic [7:0]  wbyte;
    logic        wlane;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ewio_state_s;

  ewio_state_s s_reg;
  ewio_state_s s_next;

  logic       seg_top;
  logic [7:0] gpio_mask;
  logic [7:0] wake_fall;
  logic [7:0] port_read;
  logic [7:0] ist_clr;

  assign seg_top   = segment_select_field[EWIO_SEG_TOP];
  // pin in general io use: not a wake input and not a segment
  assign gpio_mask = ~s_reg.pfs & {8{~seg_top}};
  // active-low wake input: a falling level on a wake pin is an event
  assign wake_fall = s_reg.pin_prev & ~pin_in & s_reg.pfs
                     & {8{~seg_top}};
  assign port_read = (s_reg.dir & s_reg.pdl)
                     | (~s_reg.dir & pin_in);

  always_comb begin
    s_next          = s_reg;
    ist_clr         = 8'h00;
    s_next.pin_prev = pin_in;

    // write address and data, taken in either order
    if (awvalid && s_reg.awready) begin
      s_next.waddr   = awaddr;
      s_next.aw_got  = 1'b1;
      s_next.awready = 1'b0;
    end
    if (wvalid && s_reg.wready) begin
      s_next.wbyte  = wdata[7:0];
      s_next.wlane  = wstrb[0];
      s_next.w_got  = 1'b1;
      s_next.wready = 1'b0;
    end

    // register write once both halves are in
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = EWIO_RESP_OKAY;
      case (s_reg.waddr)
        EWIO_ADDR_PFS: begin
          if (s_reg.wlane) s_next.pfs = s_reg.wbyte;
        end
        EWIO_ADDR_PDL: begin
          if (s_reg.wlane) s_next.pdl = s_reg.wbyte;
        end
        EWIO_ADDR_PUE: begin
          if (s_reg.wlane) s_next.pue = s_reg.wbyte;
        end
        EWIO_ADDR_DIR: begin
          if (s_reg.wlane) s_next.dir = s_reg.wbyte;
        end
        EWIO_ADDR_IST: begin
          if (s_reg.wlane) ist_clr = s_reg.wbyte;
        end
        EWIO_ADDR_IMASK: begin
          if (s_reg.wlane) s_next.imask = s_reg.wbyte;
        end
        default: begin
          s_next.bresp = EWIO_RESP_SLVERR;
        end
      endcase
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid  = 1'b0;
      s_next.awready = 1'b1;
      s_next.wready  = 1'b1;
    end

    // read
    if (arvalid && s_reg.arready) begin
      s_next.arready = 1'b0;
      s_next.rvalid  = 1'b1;
      s_next.rresp   = EWIO_RESP_OKAY;
      s_next.rdata   = 32'h00000000;
      case (araddr)
        EWIO_ADDR_PFS:   s_next.rdata[7:0] = s_reg.pfs;
        EWIO_ADDR_PDL:   s_next.rdata[7:0] = port_read;
        EWIO_ADDR_PUE:   s_next.rdata[7:0] = s_reg.pue;
        EWIO_ADDR_DIR:   s_next.rdata[7:0] = EWIO_DIR_READ;
        EWIO_ADDR_IST:   s_next.rdata[7:0] = s_reg.ist;
        EWIO_ADDR_IMASK: s_next.rdata[7:0] = s_reg.imask;
        default:         s_next.rresp      = EWIO_RESP_SLVERR;
      endcase
    end
    if (s_reg.rvalid && rready) begin
      s_next.rvalid  = 1'b0;
      s_next.arready = 1'b1;
    end

    // sticky wake status, a new event wins over a clear
    s_next.ist = (s_reg.ist & ~ist_clr) | wake_fall;
    s_next.irq = |(s_next.ist & s_next.imask);

    // pin drive: segment overrides, else latch on general io outputs
    if (seg_top) begin
      s_next.pin_oe  = 8'hff;
      s_next.pin_out = lcd_segment_output;
    end else begin
      s_next.pin_oe  = s_reg.dir & gpio_mask;
      s_next.pin_out = s_reg.pdl & gpio_mask;
    end
    s_next.pull = ~s_reg.dir & s_reg.pue;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg          <= '0;
      s_reg.pfs      <= EWIO_RST_PFS;
      s_reg.pdl      <= EWIO_RST_PDL;
      s_reg.pue      <= EWIO_RST_PUE;
      s_reg.dir      <= EWIO_RST_DIR;
      s_reg.ist      <= EWIO_RST_IST;
      s_reg.imask    <= EWIO_RST_IMASK;
      s_reg.awready  <= 1'b1;
      s_reg.wready   <= 1'b1;
      s_reg.arready  <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign awready   = s_reg.awready;
  assign wready    = s_reg.wready;
  assign bvalid    = s_reg.bvalid;
  assign bresp     = s_reg.bresp;
  assign arready   = s_reg.arready;
  assign rvalid    = s_reg.rvalid;
  assign rdata     = s_reg.rdata;
  assign rresp     = s_reg.rresp;
  assign pin_out   = s_reg.pin_out;
  assign pin_oe    = s_reg.pin_oe;
  assign pullup_on = s_reg.pull;
  assign irq       = s_reg.irq;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_values: assert property (disable iff (1'b0)
    !aresetn |=> (s_reg.pdl == 8'h00 && s_reg.dir == 8'h00
                  && s_reg.pue == 8'h00 && s_reg.pfs == 8'h00))
    else $error("port registers not cleared by reset");

  a_data_read: assert property (
    (arvalid && arready && araddr == EWIO_ADDR_PDL)
    |=> rvalid && rdata[7:0] == (($past(s_reg.dir) & $past(s_reg.pdl))
                                 | (~$past(s_reg.dir) & $past(pin_in))))
    else $error("data read mixes latch and pins wrongly");

  a_dir_readback: assert property (
    (arvalid && arready && araddr == EWIO_ADDR_DIR)
    |=> rvalid && rdata == 32'h000000ff && rresp == EWIO_RESP_OKAY)
    else $error("direction read not all ones");

  a_gpio_drive: assert property (
    !seg_top |=> pin_oe == ($past(s_reg.dir) & ~$past(s_reg.pfs))
                 && pin_out == ($past(s_reg.pdl) & ~$past(s_reg.pfs)))
    else $error("general io drive does not follow direction and latch");

  a_seg_override: assert property (
    seg_top |=> pin_oe == 8'hff && pin_out == $past(lcd_segment_output))
    else $error("segment select did not take the pins");

  a_pull_gate: assert property (
    ##1 pullup_on == (~$past(s_reg.dir) & $past(s_reg.pue)))
    else $error("pull-up not gated by direction");

  a_wake_sets: assert property (
    (|wake_fall) |=> ((s_reg.ist & $past(wake_fall)) == $past(wake_fall)))
    else $error("wake edge lost from status");

  a_dir_write: assert property (
    (s_reg.aw_got && s_reg.w_got && !bvalid && s_reg.wlane
     && s_reg.waddr == EWIO_ADDR_DIR && !seg_top && s_reg.pfs == 8'h00)
    |=> ##1 pin_oe == ($past(seg_top) ? 8'hff : $past(s_reg.wbyte, 2)))
    else $error("direction write not seen on pin enables");

  a_irq_level: assert property (
    irq == |(s_reg.ist & s_reg.imask))
    else $error("interrupt does not match masked status");

  a_resp_hold: assert property (
    (rvalid && !rready) |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped before taken");

  a_pin_reset: assert property (disable iff (1'b0)
    !aresetn |=> (pin_oe == 8'h00 && pin_out == 8'h00
                  && pullup_on == 8'h00 && irq == 1'b0))
    else $error("pin outputs not quiet after reset");

  a_fsel_write: assert property (
    (s_reg.aw_got && s_reg.w_got && !bvalid && s_reg.wlane
     && s_reg.waddr == EWIO_ADDR_PFS)
    |=> s_reg.pfs == $past(s_reg.wbyte))
    else $error("function select write lost");

  a_latch_write: assert property (
    (s_reg.aw_got && s_reg.w_got && !bvalid && s_reg.wlane
     && s_reg.waddr == EWIO_ADDR_PDL)
    |=> s_reg.pdl == $past(s_reg.wbyte))
    else $error("data latch write lost");

  a_lane_skip: assert property (
    (s_reg.aw_got && s_reg.w_got && !bvalid && !s_reg.wlane)
    |=> $stable(s_reg.pfs) && $stable(s_reg.pdl) && $stable(s_reg.pue)
        && $stable(s_reg.dir) && $stable(s_reg.imask))
    else $error("write without lane zero changed a register");

  a_ready_low: assert property (
    bvalid |-> !awready && !wready)
    else $error("write channel ready while answer pending");

  a_wake_blocked: assert property (
    seg_top |=> (s_reg.ist & ~$past(s_reg.ist)) == 8'h00)
    else $error("segment pin raised a wake event");

  a_status_clear: assert property (
    (ist_clr != 8'h00 && wake_fall == 8'h00)
    |=> (s_reg.ist & $past(ist_clr)) == 8'h00)
    else $error("status bit not cleared by write of one");

  a_rdata_high: assert property (
    rvalid |-> rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

endmodule // ewio_port

// [include/ewio_pkg.sv]
// Purpose: shared constants of the eight-bit wake-capable io port
// Assumes: axi4-lite slave, 32-bit data, register index times four = byte
// Notes:   printed offsets are indices since not all are word aligned
package ewio_pkg;
  localparam int unsigned EWIO_PINS   = 8;
  localparam int unsigned EWIO_AW     = 18;
  localparam int unsigned EWIO_DW     = 32;

  // register indices
  localparam logic [15:0] EWIO_IDX_PFS   = 16'hffcc;
  localparam logic [15:0] EWIO_IDX_PDL   = 16'hffd8;
  localparam logic [15:0] EWIO_IDX_PUE   = 16'hffe2;
  localparam logic [15:0] EWIO_IDX_DIR   = 16'hffe8;
  localparam logic [15:0] EWIO_IDX_IST   = 16'hfff0;
  localparam logic [15:0] EWIO_IDX_IMASK = 16'hfff1;

  // byte addresses
  localparam logic [17:0] EWIO_ADDR_PFS   = {EWIO_IDX_PFS, 2'b00};
  localparam logic [17:0] EWIO_ADDR_PDL   = {EWIO_IDX_PDL, 2'b00};
  localparam logic [17:0] EWIO_ADDR_PUE   = {EWIO_IDX_PUE, 2'b00};
  localparam logic [17:0] EWIO_ADDR_DIR   = {EWIO_IDX_DIR, 2'b00};
  localparam logic [17:0] EWIO_ADDR_IST   = {EWIO_IDX_IST, 2'b00};
  localparam logic [17:0] EWIO_ADDR_IMASK = {EWIO_IDX_IMASK, 2'b00};

  // reset values and the fixed direction read value
  localparam logic [7:0] EWIO_RST_PFS   = 8'h00;
  localparam logic [7:0] EWIO_RST_PDL   = 8'h00;
  localparam logic [7:0] EWIO_RST_PUE   = 8'h00;
  localparam logic [7:0] EWIO_RST_DIR   = 8'h00;
  localparam logic [7:0] EWIO_RST_IST   = 8'h00;
  localparam logic [7:0] EWIO_RST_IMASK = 8'h00;
  localparam logic [7:0] EWIO_DIR_READ  = 8'hff;

  // segment select field: top bit hands the pin to the lcd
  localparam int unsigned EWIO_SEG_TOP = 3;

  localparam logic [1:0] EWIO_RESP_OKAY   = 2'h0;
  localparam logic [1:0] EWIO_RESP_SLVERR = 2'h2;
endpackage

// [sim/ewio_board.sv]
// Purpose: board circuitry seen at the eight port pins
// Assumes: board drivers stay off pins that the port drives
// Notes:   an undriven pin without pull-up toggles every cycle
`timescale 1ns/1ns
module ewio_board (
  input  wire logic       aclk,      // system clock
  input  wire logic [7:0] pin_out,   // port drive values
  input  wire logic [7:0] pin_oe,    // port drive enables
  input  wire logic [7:0] pullup_on, // port weak pull-ups
  input  wire logic [7:0] ext_val,   // board drive values
  input  wire logic [7:0] ext_en,    // board drive enables
  output logic      [7:0] pin_in     // resolved pin levels
);
  logic [7:0] float_q = 8'h55;
  always @(posedge aclk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pullup_on[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_q[i];
    end
  end
endmodule // ewio_board

// [sim/eight_bit_wake_io_port_test.sv]
// Purpose: self-checking bench of the wake-capable io port
// Assumes: axi4-lite master, board model on the pins
// Notes:   undriven input pins are left out of data comparisons
`timescale 1ns/1ns
module eight_bit_wake_io_port_test;
  import ewio_pkg::*;
  logic aclk = 1'b0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata, ld, rnd;
  logic [3:0]  wstrb, segment_select_field;
  logic [1:0]  bresp, rresp, lr;
  logic [7:0]  pin_in, pin_out, pin_oe, pullup_on, lcd_segment_output;
  logic [7:0]  ext_val, ext_en, m_dir, m_pdl, m_pue, m_pfs, eoe, eout, pu;
  logic [7:0]  lvl, care;
  int mismatches = 0;
  int checked = 0;
  int seed = 87365;
  always #2 aclk = ~aclk;
  ewio_port dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .pin_in, .pin_out, .pin_oe,
    .pullup_on, .segment_select_field, .lcd_segment_output, .irq);
  ewio_board board (.aclk, .pin_out, .pin_oe, .pullup_on, .ext_val, .ext_en,
    .pin_in);
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    lr = bresp;
    if (n == 50) begin
      mismatches++;
      print_verdict();
    end
  endtask
  task automatic rd(input logic [17:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    ld = rdata;
    lr = rresp;
    if (n == 50) begin
      mismatches++;
      print_verdict();
    end
  endtask
  task automatic rdchk(input logic [17:0] a, input logic [7:0] e);
    rd(a);
    chk(ld, {24'h0, e});
    chk(lr, EWIO_RESP_OKAY);
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, segment_select_field} = '0;
    {lcd_segment_output, ext_val, ext_en} = '0;
    wstrb = 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(EWIO_ADDR_PFS, 8'h00);
    rdchk(EWIO_ADDR_PUE, 8'h00);
    rdchk(EWIO_ADDR_DIR, 8'hff);
    chk(pin_oe, 8'h00);
    wr(EWIO_ADDR_DIR, 8'hff);
    rdchk(EWIO_ADDR_PDL, 8'h00);
    for (int k = 0; k < 40; k++) begin
      rnd = $random(seed);
      {m_pfs, m_pue, m_pdl, m_dir} = rnd;
      m_pfs = m_pfs & m_pue;
      rnd = $random(seed);
      ext_en <= rnd[7:0];
      ext_val <= rnd[15:8];
      lcd_segment_output <= rnd[23:16];
      segment_select_field <= rnd[27:24];
      wr(EWIO_ADDR_DIR, m_dir);
      wr(EWIO_ADDR_PDL, m_pdl);
      wr(EWIO_ADDR_PUE, m_pue);
      wr(EWIO_ADDR_PFS, m_pfs);
      repeat (2) @(posedge aclk);
      eoe = segment_select_field[3] ? 8'hff : m_dir & ~m_pfs;
      eout = segment_select_field[3] ? lcd_segment_output : m_pdl & ~m_pfs;
      pu = ~m_dir & m_pue;
      chk(pin_oe, eoe);
      chk(pin_out, eout);
      chk(pullup_on, pu);
      lvl = (eoe & eout) | (~eoe & ext_en & ext_val) | (~eoe & ~ext_en & pu);
      care = m_dir | eoe | ext_en | pu;
      rd(EWIO_ADDR_PDL);
      chk(ld & care, ((m_dir & m_pdl) | (~m_dir & lvl)) & care);
      rdchk(EWIO_ADDR_PFS, m_pfs);
      rdchk(EWIO_ADDR_PUE, m_pue);
      rdchk(EWIO_ADDR_DIR, 8'hff);
    end
    wr(18'h00010, 8'hff);
    chk(lr, EWIO_RESP_SLVERR);
    rd(18'h00010);
    chk(ld, 32'h0);
    chk(lr, EWIO_RESP_SLVERR);
    wstrb <= 4'he;
    wr(EWIO_ADDR_PFS, 8'hff);
    chk(lr, EWIO_RESP_OKAY);
    wstrb <= 4'hf;
    rdchk(EWIO_ADDR_PFS, m_pfs);
    segment_select_field <= 4'h0;
    ext_en <= 8'hff;
    ext_val <= 8'hff;
    wr(EWIO_ADDR_DIR, 8'h00);
    wr(EWIO_ADDR_PFS, 8'h01);
    wr(EWIO_ADDR_IMASK, 8'h01);
    rdchk(EWIO_ADDR_IMASK, 8'h01);
    wr(EWIO_ADDR_IST, 8'hff);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    ext_val <= 8'hfc;
    repeat (4) @(posedge aclk);
    chk(irq, 1'b1);
    rdchk(EWIO_ADDR_IST, 8'h01);
    wr(EWIO_ADDR_IST, 8'h01);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    wr(EWIO_ADDR_IMASK, 8'h00);
    ext_val <= 8'hff;
    repeat (3) @(posedge aclk);
    ext_val <= 8'hfc;
    repeat (4) @(posedge aclk);
    chk(irq, 1'b0);
    rdchk(EWIO_ADDR_IST, 8'h01);
    wr(EWIO_ADDR_IST, 8'hff);
    wr(EWIO_ADDR_IMASK, 8'h01);
    lcd_segment_output <= 8'hff;
    segment_select_field <= 4'h8;
    repeat (3) @(posedge aclk);
    lcd_segment_output <= 8'hfe;
    repeat (4) @(posedge aclk);
    chk(irq, 1'b0);
    rdchk(EWIO_ADDR_IST, 8'h00);
    wr(EWIO_ADDR_PDL, 8'ha5);
    wr(EWIO_ADDR_PUE, 8'hff);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(pin_oe, 8'h00);
    chk(pullup_on, 8'h00);
    aresetn <= 1'b1;
    rdchk(EWIO_ADDR_PFS, 8'h00);
    rdchk(EWIO_ADDR_PUE, 8'h00);
    wr(EWIO_ADDR_DIR, 8'hff);
    rdchk(EWIO_ADDR_PDL, 8'h00);
    print_verdict();
  end
endmodule // eight_bit_wake_io_port_test
